// >>> src/fpd_display_select.sv
/*
 Front-panel display selector with power-on address display and the
 torque flag and backlash selection objects.
 Assumes the rotary switch is an asynchronous pin; all other inputs come
 from logic on sys_clk. Object requests are single-cycle strobes.
*/
`default_nettype none
module fpd_display_select #(
    parameter logic [fpd_pkg::STEP_CNT_W-1:0] STEP_CYCLES = fpd_pkg::STEP_CNT_W'(fpd_pkg::ADDR_STEP_CYC),
    parameter int                             ERR_W       = 16
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire fpd_pkg::fpd_obj_req_t objReq,
    output fpd_pkg::fpd_obj_rsp_t      objRsp,
    input  wire logic                  servoOn,
    input  wire logic [15:0]           mechCount,
    input  wire logic [15:0]           elecCount,
    input  wire logic                  incEncoder,
    input  wire logic                  zeroDetect,
    input  wire logic                  fbErrEvt,
    input  wire logic                  encErrEvt,
    input  wire logic                  extErrEvt,
    input  wire logic [7:0]            rotarySwitch,
    input  wire logic                  fullyClosed,
    input  wire logic                  extIncremental,
    input  wire logic [7:0]            zPhaseCount,
    input  wire logic                  torqueCtrl,
    input  wire logic                  limitInclCmd,
    input  wire logic                  limitExclCmd,
    input  wire logic                  positionCtrl,
    input  wire logic                  moveFwd,
    input  wire logic                  moveRev,
    output fpd_pkg::fpd_disp_t         dispOut,
    output logic                       torqueLimitFlag,
    output logic                       backlashEnable,
    output logic                       backlashReverse,
    output logic                       backlashStart
);
    import fpd_pkg::*;

    localparam logic [1:0] SETTLE_LAST = 2'(SYNC_SETTLE);
    localparam logic [STEP_CNT_W-1:0] PRE_ONE = STEP_CNT_W'(1);
    localparam logic [9:0] STEP_ONE = 10'h001;

    fpd_state_t st_reg;
    fpd_state_t st_next;
    logic [ERR_W-1:0] fbCount;
    logic [ERR_W-1:0] encCount;
    logic [ERR_W-1:0] extCount;
    logic [7:0] nodeDec;
    logic [7:0] nodeRem;
    logic       wrOk;
    logic       idxOk;

    fpd_sat_counter #(.WIDTH(ERR_W)) u_fb_err (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .incr(fbErrEvt),
        .count(fbCount)
    );

    fpd_sat_counter #(.WIDTH(ERR_W)) u_enc_err (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .incr(encErrEvt),
        .count(encCount)
    );

    fpd_sat_counter #(.WIDTH(ERR_W)) u_ext_err (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .incr(extErrEvt),
        .count(extCount)
    );

    // Two decimal digits of the latched address
    always_comb begin
        nodeRem = st_reg.nodeAddr % DEC_MOD;
        nodeDec = {4'(nodeRem / DEC_BASE), 4'(nodeRem % DEC_BASE)};  // [RL8]
    end

    // Object index decode and range check
    always_comb begin
        idxOk = 1'b1;
        wrOk  = 1'b0;
        unique case (objReq.index)
            IDX_DISP_SEL:  wrOk = objReq.data <= MAX_DISP_SEL;  // [RL16]
            IDX_ADDR_TIME: wrOk = objReq.data <= MAX_ADDR_TIME;  // [RL12]
            IDX_TQ_COND:   wrOk = objReq.data <= MAX_TQ_COND;
            IDX_BL_SEL:    wrOk = objReq.data <= MAX_BL_SEL;  // [RL14]
            default:       idxOk = 1'b0;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.swMeta = rotarySwitch;
        st_next.swSync = st_reg.swMeta;
        st_next.servoOnD = servoOn;
        st_next.blPulse = 1'b0;

        // Object access
        st_next.rsp.ack  = objReq.wr | objReq.rd;
        st_next.rsp.err  = 1'b0;
        st_next.rsp.data = 16'h0000;
        if (objReq.rd) begin
            st_next.rsp.err = !idxOk;
            unique case (objReq.index)
                IDX_DISP_SEL:  st_next.rsp.data = st_reg.dispSel;
                IDX_ADDR_TIME: st_next.rsp.data = st_reg.addrTime;
                IDX_TQ_COND:   st_next.rsp.data = st_reg.tqCond;
                IDX_BL_SEL:    st_next.rsp.data = st_reg.blSel;
                default:       st_next.rsp.data = 16'h0000;
            endcase
        end else if (objReq.wr) begin
            st_next.rsp.err = !(idxOk && wrOk);
            if (idxOk && wrOk) begin
                unique case (objReq.index)
                    IDX_DISP_SEL:  st_next.dispSel = objReq.data;  // [RL16]
                    IDX_ADDR_TIME: st_next.addrTime = objReq.data;
                    IDX_TQ_COND:   st_next.tqCond = objReq.data;
                    IDX_BL_SEL:    st_next.blSel = objReq.data;
                    default:       st_next.dispSel = st_reg.dispSel;
                endcase
            end
        end

        // Zero position seen once after power-on
        if (zeroDetect) begin
            st_next.zeroSeen = 1'b1;  // [RL4]
        end

        // Power-on sequencing and address display
        unique case (st_reg.phase)
            PH_LATCH: begin
                st_next.disp = '{blank: 1'b1, notFixedIndicator: 1'b0, digits: DIGITS_ZERO};
                if (st_reg.settle == SETTLE_LAST) begin
                    st_next.nodeAddr = st_reg.swSync;  // [RL8]
                    st_next.phase = PH_ADDR;
                end else begin
                    st_next.settle = st_reg.settle + 2'b01;
                end
            end
            PH_ADDR: begin
                st_next.disp = '{blank: 1'b0, notFixedIndicator: 1'b0, digits: nodeDec};
                if (st_reg.stepCnt >= st_reg.addrTime[9:0]) begin
                    st_next.phase = PH_RUN;  // [RL12]
                end else if (st_reg.preCnt == STEP_CYCLES - PRE_ONE) begin
                    st_next.preCnt = '0;
                    st_next.stepCnt = st_reg.stepCnt + STEP_ONE;  // [RL12]
                end else begin
                    st_next.preCnt = st_reg.preCnt + PRE_ONE;
                end
            end
            PH_RUN: begin
                st_next.disp = '{blank: 1'b0, notFixedIndicator: 1'b0, digits: DIGITS_ZERO};
                unique case (st_reg.dispSel)
                    SEL_NORMAL: st_next.disp.blank = !servoOn;  // [RL1]
                    SEL_MECH: begin
                        if (incEncoder && !st_reg.zeroSeen) begin
                            st_next.disp.notFixedIndicator = 1'b1;  // [RL4]
                        end else begin
                            st_next.disp.digits = mechCount[7:0];  // [RL2] [RL3]
                        end
                    end
                    SEL_ELEC:    st_next.disp.digits = elecCount[7:0];  // [RL5] [RL3]
                    SEL_FB_ERR:  st_next.disp.digits = fbCount[7:0];  // [RL6]
                    SEL_NODE:    st_next.disp.digits = nodeDec;  // [RL8]
                    SEL_ENC_ERR: st_next.disp.digits = encCount[7:0];  // [RL7]
                    SEL_EXT_ERR: st_next.disp.digits = extCount[7:0];  // [RL7]
                    SEL_ZPHASE: begin
                        if (fullyClosed && extIncremental) begin
                            st_next.disp.digits = zPhaseCount;  // [RL9]
                        end else begin
                            st_next.disp.blank = 1'b1;
                        end
                    end
                    default: st_next.disp.blank = !servoOn;  // [RL17] [RL10]
                endcase
            end
        endcase

        // Torque limit flag condition
        if (st_reg.tqCond[0]) begin
            st_next.tqFlag = torqueCtrl && limitExclCmd;  // [RL13]
        end else begin
            st_next.tqFlag = torqueCtrl && limitInclCmd;  // [RL13]
        end

        // Backlash compensation arming
        st_next.blEnable  = positionCtrl && st_reg.blSel != BL_OFF;  // [RL14]
        st_next.blReverse = st_reg.blSel == BL_REV;  // [RL15]
        if (!servoOn) begin
            st_next.blArmed = 1'b0;
        end else if (servoOn && !st_reg.servoOnD && st_reg.blSel != BL_OFF) begin
            st_next.blArmed = 1'b1;  // [RL15]
        end else if (st_reg.blArmed && positionCtrl &&
                     ((st_reg.blSel == BL_FWD && moveFwd) || (st_reg.blSel == BL_REV && moveRev))) begin
            st_next.blArmed = 1'b0;
            st_next.blPulse = 1'b1;  // [RL15]
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.phase <= PH_LATCH;
            st_reg.dispSel <= RST_DISP_SEL;
            st_reg.addrTime <= RST_ADDR_TIME;
            st_reg.tqCond <= RST_TQ_COND;
            st_reg.blSel <= RST_BL_SEL;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign objRsp          = st_reg.rsp;
    assign dispOut         = st_reg.disp;
    assign torqueLimitFlag = st_reg.tqFlag;
    assign backlashEnable  = st_reg.blEnable;
    assign backlashReverse = st_reg.blReverse;
    assign backlashStart   = st_reg.blPulse;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic runNow;
    assign runNow = ce && st_reg.phase == PH_RUN;

    chk_normal_blank: assert property (runNow && st_reg.dispSel == SEL_NORMAL  // [RL1]
        |=> dispOut.blank == !$past(servoOn))
        else $error("normal display blank wrong");

    chk_mech_angle: assert property (runNow && st_reg.dispSel == SEL_MECH  // [RL2]
        && (!incEncoder || st_reg.zeroSeen) |=> dispOut.digits == $past(mechCount[7:0]))
        else $error("mechanical angle wrong");

    chk_not_fixed: assert property (runNow && st_reg.dispSel == SEL_MECH && incEncoder  // [RL4]
        && !st_reg.zeroSeen |=> dispOut.notFixedIndicator)
        else $error("not fixed indicator missing");

    chk_elec_angle: assert property (runNow && st_reg.dispSel == SEL_ELEC  // [RL5]
        |=> dispOut.digits == $past(elecCount[7:0]) && !dispOut.blank)
        else $error("electrical angle wrong");

    chk_fb_low_byte: assert property (runNow && st_reg.dispSel == SEL_FB_ERR  // [RL6]
        |=> dispOut.digits == $past(fbCount[7:0]))
        else $error("fieldbus error byte wrong");

    chk_enc_low_byte: assert property (runNow && st_reg.dispSel == SEL_ENC_ERR  // [RL7]
        |=> dispOut.digits == $past(encCount[7:0]))
        else $error("encoder error byte wrong");

    chk_ext_low_byte: assert property (runNow && st_reg.dispSel == SEL_EXT_ERR  // [RL7]
        |=> dispOut.digits == $past(extCount[7:0]))
        else $error("external encoder error byte wrong");

    chk_node_hold: assert property (st_reg.phase != PH_LATCH  // [RL8]
        |=> $stable(st_reg.nodeAddr))
        else $error("node address changed after latch");

    chk_zphase_raw: assert property (runNow && st_reg.dispSel == SEL_ZPHASE  // [RL9]
        && fullyClosed && extIncremental |=> dispOut.digits == $past(zPhaseCount))
        else $error("z phase count wrong");

    chk_addr_shown: assert property (ce && st_reg.phase == PH_ADDR  // [RL12]
        |=> !dispOut.blank && dispOut.digits == $past(nodeDec))
        else $error("address display wrong");

    chk_addr_end: assert property (ce && st_reg.phase == PH_ADDR  // [RL12]
        && st_reg.stepCnt >= st_reg.addrTime[9:0] |=> st_reg.phase == PH_RUN)
        else $error("address display did not end");

    chk_torque_flag: assert property (ce  // [RL13]
        |=> torqueLimitFlag == ($past(torqueCtrl)
            && ($past(st_reg.tqCond[0]) ? $past(limitExclCmd) : $past(limitInclCmd))))
        else $error("torque flag wrong");

    chk_bl_select: assert property (ce  // [RL14]
        |=> backlashEnable == ($past(positionCtrl) && $past(st_reg.blSel) != BL_OFF)
            && backlashReverse == ($past(st_reg.blSel) == BL_REV))
        else $error("backlash selection wrong");

    chk_bl_start: assert property (backlashStart  // [RL15]
        |-> $past(st_reg.blArmed) && !st_reg.blArmed)
        else $error("backlash start without arming");

    chk_sel_refuse: assert property (ce && objReq.wr && !objReq.rd && objReq.index == IDX_DISP_SEL  // [RL16]
        && objReq.data[15] |=> objRsp.err && $stable(st_reg.dispSel))
        else $error("out of range selection accepted");

    chk_unused_sel: assert property (runNow && st_reg.dispSel > SEL_ZPHASE && servoOn  // [RL17]
        |=> !dispOut.blank && dispOut.digits == DIGITS_ZERO)
        else $error("unused selection not normal");

    cov_addr_phase: cover property (st_reg.phase == PH_ADDR ##1 st_reg.phase == PH_RUN);
    cov_not_fixed: cover property (dispOut.notFixedIndicator);
    cov_bl_start: cover property (backlashStart);
    cov_node_sel: cover property (runNow && st_reg.dispSel == SEL_NODE);
endmodule
`default_nettype wire

// >>> src/fpd_pkg.sv
/*
 Constants, enumerations and carrier types for the front-panel display
 selector and its setting objects.
 Assumes one 50 MHz system clock and an object port driven by the
 fieldbus stack.
*/
// Functional notes
// (RL1) Selection 0: blank while servo off, 00 while servo on.
// (RL2) Selection 1: mechanical angle low byte, 0 at encoder zero.
// (RL3) Angle displays wrap FF to 0 while underlying count keeps running.
// (RL4) Incremental encoder: not-fixed indicator until zero first detected after power-on.
// (RL5) Selection 2: electrical angle low byte, 0 at U-phase positive peak.
// (RL6) Selection 3: fieldbus error count saturates at FFFF, low byte shown.
// (RL7) Selections 5 and 6: encoder and external-encoder error counts, low byte.
// (RL8) Selection 4: node address latched at power-on, shown in decimal.
// (RL9) Selection 7: raw external Z-phase count during fully-closed incremental control.
// (RL10) Host must not write display selection values of 8 or above.
// (RL11) Error counts clear only on control power removal.
// (RL12) Node address shown at power-on for setting times 100 ms, 0..1000.
// (RL13) Torque flag uses limit including command at 0, excluding at 1.
// (RL14) Backlash select 1 or 2 enables compensation and picks direction in position control.
// (RL15) Backlash 0 off, 1 first forward move, 2 first reverse move after servo on.
// (RL16) Display selection is 16-bit read-write, default 0, range 0..32767.
// (RL17) Unused selection values fall back to the normal-state display.
`default_nettype none
package fpd_pkg;
    localparam int CLK_HZ         = 50_000_000;
    localparam int ADDR_STEP_MS   = 100;
    localparam int ADDR_STEP_CYC  = CLK_HZ / 1000 * ADDR_STEP_MS;
    localparam int STEP_CNT_W     = 23;
    localparam int SYNC_SETTLE    = 2;

    localparam logic [15:0] IDX_DISP_SEL  = 16'h3700;
    localparam logic [15:0] IDX_ADDR_TIME = 16'h3701;
    localparam logic [15:0] IDX_TQ_COND   = 16'h3703;
    localparam logic [15:0] IDX_BL_SEL    = 16'h3704;

    localparam logic [15:0] RST_DISP_SEL  = 16'h0000;
    localparam logic [15:0] RST_ADDR_TIME = 16'h0000;
    localparam logic [15:0] RST_TQ_COND   = 16'h0000;
    localparam logic [15:0] RST_BL_SEL    = 16'h0000;

    localparam logic [15:0] MAX_DISP_SEL  = 16'h7FFF;
    localparam logic [15:0] MAX_ADDR_TIME = 16'h03E8;
    localparam logic [15:0] MAX_TQ_COND   = 16'h0001;
    localparam logic [15:0] MAX_BL_SEL    = 16'h0002;

    localparam logic [15:0] SEL_NORMAL    = 16'h0000;
    localparam logic [15:0] SEL_MECH      = 16'h0001;
    localparam logic [15:0] SEL_ELEC      = 16'h0002;
    localparam logic [15:0] SEL_FB_ERR    = 16'h0003;
    localparam logic [15:0] SEL_NODE      = 16'h0004;
    localparam logic [15:0] SEL_ENC_ERR   = 16'h0005;
    localparam logic [15:0] SEL_EXT_ERR   = 16'h0006;
    localparam logic [15:0] SEL_ZPHASE    = 16'h0007;

    localparam logic [15:0] BL_OFF        = 16'h0000;
    localparam logic [15:0] BL_FWD        = 16'h0001;
    localparam logic [15:0] BL_REV        = 16'h0002;

    localparam logic [7:0]  DEC_MOD       = 8'h64;
    localparam logic [7:0]  DEC_BASE      = 8'h0A;
    localparam logic [7:0]  DIGITS_ZERO   = 8'h00;
    localparam logic [15:0] ERR_CNT_MAX   = 16'hFFFF;

    typedef enum logic [2:0] {
        PH_LATCH = 3'b001,
        PH_ADDR  = 3'b010,
        PH_RUN   = 3'b100
    } fpd_phase_t;

    typedef struct packed {
        logic       blank;
        logic       notFixedIndicator;
        logic [7:0] digits;
    } fpd_disp_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [15:0] data;
    } fpd_obj_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] data;
    } fpd_obj_rsp_t;

    typedef struct packed {
        fpd_phase_t   phase;
        logic [1:0]   settle;
        logic [7:0]   swMeta;
        logic [7:0]   swSync;
        logic [7:0]   nodeAddr;
        logic [STEP_CNT_W-1:0] preCnt;
        logic [9:0]   stepCnt;
        logic [15:0]  dispSel;
        logic [15:0]  addrTime;
        logic [15:0]  tqCond;
        logic [15:0]  blSel;
        logic         zeroSeen;
        logic         servoOnD;
        logic         blArmed;
        logic         blPulse;
        logic         tqFlag;
        logic         blEnable;
        logic         blReverse;
        fpd_disp_t    disp;
        fpd_obj_rsp_t rsp;
    } fpd_state_t;
endpackage
`default_nettype wire

// >>> src/fpd_sat_counter.sv
/*
 Saturating event counter for cumulative communication errors.
 Assumes one-cycle event pulses on the system clock.
*/
`default_nettype none
module fpd_sat_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             incr,
    output logic [WIDTH-1:0]      count
);
    import fpd_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } fpd_cnt_state_t;

    localparam logic [WIDTH-1:0] CNT_MAX = '1;
    localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);

    fpd_cnt_state_t st_reg;
    fpd_cnt_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (incr && st_reg.cnt != CNT_MAX) begin
            st_next.cnt = st_reg.cnt + CNT_ONE;  // [RL6] [RL7]
        end
    end

    // Cleared by power-on reset only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;  // [RL11]
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.cnt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_sat_hold_max: assert property (st_reg.cnt == CNT_MAX |=> st_reg.cnt == CNT_MAX) // [RL6]
        else $error("error count left saturation");
    chk_count_step: assert property (ce && incr && st_reg.cnt != CNT_MAX  // [RL7]
        |=> st_reg.cnt == $past(st_reg.cnt) + CNT_ONE)
        else $error("error count did not step");
    chk_count_idle: assert property (!incr |=> $stable(st_reg.cnt)) // [RL11]
        else $error("error count changed without event");
    cov_saturate: cover property (st_reg.cnt == CNT_MAX && incr);
endmodule
`default_nettype wire

// >>> tb/fpd_host_model.sv
/*
 Host model that reads and writes setting objects over the fieldbus port.
 Assumes the testbench owns the clock and calls access.
*/
`default_nettype none
module fpd_host_model
    import fpd_pkg::*;
(
    input  wire logic                  sys_clk,
    output var fpd_pkg::fpd_obj_req_t  objReq,
    input  wire fpd_pkg::fpd_obj_rsp_t objRsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic allowUnused = 1'b0;
    initial objReq = '0;
    // One-cycle strobe, index and data held until ack
    task automatic access(input logic wr, input logic [15:0] index, input logic [15:0] data);
        int n;
        n = 0;
        if (wr && index == IDX_DISP_SEL && data > SEL_ZPHASE && data <= MAX_DISP_SEL && !allowUnused) begin
            data = SEL_NORMAL;
        end
        @(negedge sys_clk);
        objReq = '{wr: wr, rd: !wr, index: index, data: data};
        @(negedge sys_clk);
        objReq.wr = 1'b0;
        objReq.rd = 1'b0;
        while (objRsp.ack !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        objReq.index = ~index;
        objReq.data  = ~data;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 Self-checking testbench for the front-panel display selector.
 Assumes fpd_pkg and the host model are compiled before it.
*/
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fpd_pkg::*;
    localparam int ERR_BITS = 9;
    localparam int SAT      = 2 ** ERR_BITS - 1;
    localparam logic [15:0] IDX_T [4] = '{IDX_DISP_SEL, IDX_ADDR_TIME, IDX_TQ_COND, IDX_BL_SEL};
    localparam logic [15:0] BAD_T [4] = '{16'h8000, 16'h03E9, 16'h0002, 16'h0003};
    localparam logic [15:0] OK_T  [4] = '{16'h0007, 16'h03E8, 16'h0001, 16'h0002};
    localparam logic [15:0] CSEL  [3] = '{SEL_FB_ERR, SEL_ENC_ERR, SEL_EXT_ERR};
    logic         sys_clk = 1'b0;
    logic         resetn  = 1'b0;
    logic         ce      = 1'b1;
    logic         servoOn, incEncoder, zeroDetect, fullyClosed, extInc;
    logic         torqueCtrl, limIncl, limExcl, posCtrl, moveFwd, moveRev;
    logic         tqFlag, blEn, blRev, blStart;
    logic [2:0]   evt;
    logic [7:0]   sw, swLatched, zPhase;
    logic [15:0]  mech, elec;
    fpd_obj_req_t objReq;
    fpd_obj_rsp_t objRsp;
    fpd_disp_t    disp;
    fpd_obj_rsp_t expQ [$];
    int           fails, checked;
    int           cnt [3];

    always #10 sys_clk = ~sys_clk;

    fpd_host_model u_host (.sys_clk(sys_clk), .objReq(objReq), .objRsp(objRsp));

    fpd_display_select #(.STEP_CYCLES(STEP_CNT_W'(4)), .ERR_W(ERR_BITS)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .objReq(objReq), .objRsp(objRsp),
        .servoOn(servoOn), .mechCount(mech), .elecCount(elec), .incEncoder(incEncoder),
        .zeroDetect(zeroDetect), .fbErrEvt(evt[0]), .encErrEvt(evt[1]), .extErrEvt(evt[2]),
        .rotarySwitch(sw), .fullyClosed(fullyClosed), .extIncremental(extInc), .zPhaseCount(zPhase),
        .torqueCtrl(torqueCtrl), .limitInclCmd(limIncl), .limitExclCmd(limExcl),
        .positionCtrl(posCtrl), .moveFwd(moveFwd), .moveRev(moveRev), .dispOut(disp),
        .torqueLimitFlag(tqFlag), .backlashEnable(blEn), .backlashReverse(blRev), .backlashStart(blStart));

    function automatic logic [7:0] dec(input logic [7:0] a);
        return {4'((a % 100) / 10), 4'(a % 10)};
    endfunction

    task automatic chkRsp(input fpd_obj_rsp_t exp, input fpd_obj_rsp_t got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value objRsp expected %h seen %h", exp, got);
        end
    endtask
    task automatic chkDisp(input fpd_disp_t exp, input fpd_disp_t got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value dispOut expected %h seen %h", exp, got);
        end
    endtask
    task automatic chkNum(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Response monitor takes the oldest note
    always @(negedge sys_clk) begin
        if (objRsp.ack === 1'b1) begin
            chkRsp(expQ.size() != 0 ? expQ.pop_front() : fpd_obj_rsp_t'('0), objRsp);
        end
    end

    task automatic obj(input logic wr, input logic [15:0] idx, d, input logic err, input logic [15:0] rd);
        expQ.push_back('{ack: 1'b1, err: err, data: rd});
        u_host.access(wr, idx, d);
    endtask
    task automatic seeDisp(input logic b, input logic nf, input logic [7:0] d);
        repeat (2) @(negedge sys_clk);
        chkDisp('{blank: b, notFixedIndicator: nf, digits: d}, disp);
    endtask
    task automatic pulses(input int k, input int n);
        repeat (n) begin
            evt[k] = 1'b1;
            @(negedge sys_clk);
            evt[k] = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    task automatic moveCount(input logic fwd, input int exp);
        int n;
        n = 0;
        moveFwd = fwd;
        moveRev = !fwd;
        repeat (5) begin
            @(negedge sys_clk);
            moveFwd = 1'b0;
            moveRev = 1'b0;
            n += int'(blStart === 1'b1);
        end
        chkNum("backlashStart pulses", 16'(exp), 16'(n));
    endtask

    task automatic end_of_test;
        fails += expQ.size();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20 * 6000);
        fails++;
        end_of_test();
    end

    initial begin
        int i, n;
        logic [15:0] v;
        void'($urandom(32'h043d_8b24));
        {servoOn, zeroDetect, fullyClosed, extInc, torqueCtrl, limIncl, limExcl, posCtrl, moveFwd, moveRev} = '0;
        incEncoder = 1'b1;
        evt = '0;
        mech = '0;
        elec = '0;
        zPhase = '0;
        sw = 8'($urandom);
        swLatched = sw;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        n = 0;
        repeat (10) begin
            @(negedge sys_clk);
            n += int'(disp.blank === 1'b0 && disp.digits === dec(swLatched));
        end
        chkNum("address display cycles", 16'h0001, 16'(n));
        seeDisp(1, 0, 8'h00);
        for (i = 0; i < 4; i++) begin
            obj(0, IDX_T[i], 0, 0, 16'h0000);
            obj(1, IDX_T[i], BAD_T[i], 1, 0);
            obj(1, IDX_T[i], OK_T[i], 0, 0);
            obj(0, IDX_T[i], 0, 0, OK_T[i]);
        end
        obj(0, 16'h3702, 0, 1, 0);
        obj(1, IDX_DISP_SEL, SEL_NORMAL, 0, 0);
        servoOn = 1'b1;
        seeDisp(0, 0, 8'h00);
        u_host.allowUnused = 1'b1;
        obj(1, IDX_DISP_SEL, 16'h0008, 0, 0);
        seeDisp(0, 0, 8'h00);
        servoOn = 1'b0;
        seeDisp(1, 0, 8'h00);
        u_host.allowUnused = 1'b0;
        obj(1, IDX_DISP_SEL, SEL_MECH, 0, 0);
        seeDisp(0, 1, 8'h00);
        zeroDetect = 1'b1;
        @(negedge sys_clk);
        zeroDetect = 1'b0;
        for (i = 0; i < 6; i++) begin
            if (i % 3 == 0) obj(1, IDX_DISP_SEL, 16'(1 + i / 3), 0, 0);
            v = (i % 3 == 0) ? 16'($urandom) : 16'h12FF + 16'(i % 3 - 1);
            mech = (i < 3) ? v : ~v;
            elec = (i < 3) ? ~v : v;
            seeDisp(0, 0, v[7:0]);
        end
        obj(1, IDX_DISP_SEL, SEL_NODE, 0, 0);
        seeDisp(0, 0, dec(swLatched));
        sw = ~sw;
        seeDisp(0, 0, dec(swLatched));
        fullyClosed = 1'b1;
        extInc = 1'b1;
        zPhase = 8'($urandom);
        obj(1, IDX_DISP_SEL, SEL_ZPHASE, 0, 0);
        seeDisp(0, 0, zPhase);
        for (i = 0; i < 3; i++) begin
            cnt[i] = (i == 0 ? 260 : 1) + $urandom % 40;
            pulses(i, cnt[i]);
        end
        for (i = 0; i < 3; i++) begin
            obj(1, IDX_DISP_SEL, CSEL[i], 0, 0);
            seeDisp(0, 0, 8'(cnt[i]));
        end
        pulses(0, 300);
        obj(1, IDX_DISP_SEL, SEL_FB_ERR, 0, 0);
        seeDisp(0, 0, 8'(SAT));
        obj(1, IDX_DISP_SEL, SEL_ENC_ERR, 0, 0);
        seeDisp(0, 0, 8'(cnt[1]));
        ce = 1'b0;
        pulses(1, 3);
        ce = 1'b1;
        seeDisp(0, 0, 8'(cnt[1]));
        for (i = 0; i < 8; i++) begin
            obj(1, IDX_TQ_COND, 16'(i % 2), 0, 0);
            {torqueCtrl, limIncl, limExcl} = 3'($urandom);
            repeat (2) @(negedge sys_clk);
            chkNum("torqueLimitFlag", 16'(torqueCtrl && (i % 2 ? limExcl : limIncl)), 16'(tqFlag));
        end
        posCtrl = 1'b1;
        for (i = 0; i < 3; i++) begin
            obj(1, IDX_BL_SEL, 16'(i), 0, 0);
            servoOn = 1'b0;
            @(negedge sys_clk);
            servoOn = 1'b1;
            repeat (2) @(negedge sys_clk);
            chkNum("backlash enable and direction", 16'({i != 0, i == 2}), 16'({blEn, blRev}));
            moveCount(i == 2, 0);
            moveCount(i != 2, i != 0 ? 1 : 0);
            moveCount(i != 2, 0);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
